// *** logic/instr_decoder.sv ***
// Instruction decoder and cycle sequencer for 14-bit words.
// Assumes the word source, pointer flags and file data share clk_i.
// Notes on behaviour
// - Every instruction is one 14-bit word holding opcode and operands.
// - One cycle, except calls, returns, branches and taken skips: two cycles.
// - Indirect access through a pointer with MSB set adds one cycle.
// - One instruction cycle is four clock periods.
// - Instructions naming a file register always read it first.
// - Destination bit 0 selects working register, 1 the file register.
// - File address selects register 0x00 to 0x7F in the bank.
// - Byte ops: six-bit opcode, destination bit, 7-bit file address.
// - Bit ops: four-bit opcode, 3-bit bit number, 7-bit file address.
// - General literal ops carry an 8-bit value in the low byte.
// - Call and jump carry an 11-bit target in bits 10 to 0.
// - Page load 7 bits, bank load 5 bits, relative branch 9 bits.
// - Pointer offset ops carry pointer select and 6-bit offset.
// - Pointer increment ops carry pointer select and 2-bit mode.
// - Decode arithmetic and logic byte ops with their flag writes.
// - Decode shifts and rotates; all write carry, shifts also zero.
// - Decrement/increment skip ops take two cycles when result is zero.
// - Bit clear, set and the two bit tests; tests take two when skipping.
// - Decode literal ops, bank select load and page latch load.
// - A counter change or true test costs a second no-op cycle.
// - Don't-care bits are ignored by the decoder.
// - Call pushes, loads 11-bit target, upper bits from page latch 6:3.
// - Relative branch target is address plus one plus signed literal.
`timescale 1ns/1ps

module instr_decoder (
   input  wire logic                               clk_i,
   input  wire logic                               arst_n_i,
   input  wire logic [instr_decode_pkg::INSTR_W-1:0] instr_i,
   input  wire logic                               instr_valid_i,
   input  wire logic [instr_decode_pkg::PC_W-1:0]  pc_i,
   input  wire logic [6:0]                         page_latch_i,
   input  wire logic [1:0]                         ptr_msb_i,
   input  wire logic [7:0]                         file_data_i,
   output logic                                    instr_ready_o,
   output instr_decode_pkg::fields_t               fields_o,
   output logic                                    file_read_o,
   output logic                                    flags_we_o,
   output logic                                    push_o,
   output logic [instr_decode_pkg::PC_W-1:0]       target_pc_o,
   output logic [1:0]                              cost_o,
   output logic                                    exec_o,
   output logic                                    ind_cycle_o,
   output logic                                    nop_cycle_o
);
   import instr_decode_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   function automatic fields_t decode_word(input logic [INSTR_W-1:0] w);
      fields_t f;
      f            = '0;
      f.dest_file  = w[7];
      f.file_addr  = w[6:0];
      f.bit_num    = w[9:7];
      f.lit8       = w[7:0];
      f.lit11      = w[10:0];
      f.lit7       = w[6:0];
      f.lit5       = w[4:0];
      f.lit9       = w[8:0];
      f.offset6    = w[5:0];
      f.mode       = w[1:0];
      f.ptr_sel    = w[6];
      f.op         = OP_OTHER;
      // Low bits of the clear-working form are never compared
      if (w[13:12] == PFX_BIT) begin
         case (w[11:10])
            2'h0:    f.op = OP_BCLR;
            2'h1:    f.op = OP_BSET;
            2'h2:    f.op = OP_TSC;
            default: f.op = OP_TSS;
         endcase
      end else if (w[13:11] == PFX_CALL) begin
         f.op = OP_CALL;
      end else if (w[13:11] == PFX_JUMP) begin
         f.op = OP_JUMP;
      end else if (w[13:9] == PFX_REL) begin
         f.op = OP_BREL;
      end else if (w[13:7] == PFX_PAGE) begin
         f.op = OP_PAGE;
      end else if (w[13:7] == PFX_PADD) begin
         f.op = OP_PADD;
      end else if (w[13:7] == PFX_IDXR) begin
         f.op = OP_IDXR;
      end else if (w[13:7] == PFX_IDXW) begin
         f.op = OP_IDXW;
      end else if (w[13:8] == 6'h00) begin
         if (w[7]) begin
            f.op = OP_MOV_TO_FILE;
         end else if (w[7:5] == PFX_BANK) begin
            f.op = OP_BANK;
         end else if (w[7:4] == {1'b0, PFX_INCD}) begin
            f.op      = w[3] ? OP_INCDW : OP_INCDR;
            f.ptr_sel = w[2];
         end else if (w == W_RETURN) begin
            f.op = OP_RET;
         end else if (w == W_RETFIE) begin
            f.op = OP_RETFIE;
         end else if (w == W_CALLW) begin
            f.op = OP_CALLW;
         end else if (w == W_BRW) begin
            f.op = OP_BRW;
         end else if (w == 14'h0000) begin
            f.op = OP_NOP;
         end
      end else begin
         case (w[13:8])
            6'h07: f.op = OP_ADD;
            6'h3d: f.op = OP_ADDC;
            6'h05: f.op = OP_AND;
            6'h04: f.op = OP_OR;
            6'h06: f.op = OP_XOR;
            6'h02: f.op = OP_SUB;
            6'h3b: f.op = OP_SUBB;
            6'h37: f.op = OP_ASR;
            6'h35: f.op = OP_LSL;
            6'h36: f.op = OP_LSR;
            6'h0d: f.op = OP_RLC;
            6'h0c: f.op = OP_RRC;
            6'h01: f.op = w[7] ? OP_CLR_FILE : OP_CLR_WORK;
            6'h09: f.op = OP_COMPL;
            6'h03: f.op = OP_DEC;
            6'h0a: f.op = OP_INC;
            6'h08: f.op = OP_MOV_FILE;
            6'h0e: f.op = OP_SWAP;
            6'h0b: f.op = OP_DECSZ;
            6'h0f: f.op = OP_INCSZ;
            6'h3e: f.op = OP_ADDL;
            6'h39: f.op = OP_ANDL;
            6'h38: f.op = OP_ORL;
            6'h30: f.op = OP_MOVL;
            6'h3c: f.op = OP_SUBL;
            6'h34: f.op = OP_RETL;
            default: f.op = OP_OTHER;
         endcase
      end
      // Flag writes, file naming and cycle class per operation
      case (f.op)
         OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_ADDL, OP_SUBL:
            f.flags = '{1'b1, 1'b1, 1'b1};
         OP_ASR, OP_LSL, OP_LSR:
            f.flags = '{1'b1, 1'b0, 1'b1};
         OP_RLC, OP_RRC:
            f.flags = '{1'b1, 1'b0, 1'b0};
         OP_AND, OP_OR, OP_XOR, OP_CLR_FILE, OP_CLR_WORK, OP_COMPL, OP_DEC,
         OP_INC, OP_MOV_FILE, OP_ANDL, OP_ORL, OP_IDXR, OP_INCDR:
            f.flags = '{1'b0, 1'b0, 1'b1};
         default:
            f.flags = '0;
      endcase
      f.names_file = (w[13:12] == PFX_BIT) ||
                     (w[13:12] == 2'h0 && f.op != OP_OTHER && f.op != OP_NOP &&
                      f.op != OP_CLR_WORK && f.op != OP_BANK && f.op != OP_RET &&
                      f.op != OP_RETFIE && f.op != OP_CALLW && f.op != OP_BRW &&
                      f.op != OP_INCDR && f.op != OP_INCDW) ||
                     f.op inside {OP_ADDC, OP_SUBB, OP_ASR, OP_LSL, OP_LSR};
      f.two_cycle  = f.op inside {OP_CALL, OP_JUMP, OP_BREL, OP_BRW, OP_CALLW,
                                  OP_RET, OP_RETFIE, OP_RETL};
      f.skip_kind  = f.op inside {OP_DECSZ, OP_INCSZ, OP_TSC, OP_TSS};
      return f;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   state_t              state;
   state_t              next_state;
   logic [1:0]          q;
   logic                ind_pend;
   logic                skip_hit;
   fields_t             d;
   logic                take;
   logic                ind_now;
   logic                skip_now;
   logic [PC_W-1:0]     next_target;

   assign d    = decode_word(instr_i);
   assign take = instr_ready_o && instr_valid_i;

   // Indirect window through either pointer
   always_comb begin
      ind_now = 1'b0;
      if (d.names_file && (d.file_addr == ADDR_IND0 || d.file_addr == ADDR_IND1))
         ind_now = ptr_msb_i[d.file_addr[0]];
      else if (d.op inside {OP_IDXR, OP_IDXW, OP_INCDR, OP_INCDW})
         ind_now = ptr_msb_i[d.ptr_sel];
   end

   // Skip test on the value read back during execution
   always_comb begin
      case (fields_o.op)
         OP_DECSZ: skip_now = (file_data_i == 8'h01);
         OP_INCSZ: skip_now = (file_data_i == 8'hff);
         OP_TSC:   skip_now = !file_data_i[fields_o.bit_num];
         OP_TSS:   skip_now = file_data_i[fields_o.bit_num];
         default:  skip_now = 1'b0;
      endcase
   end

   always_comb begin
      case (d.op)
         OP_CALL, OP_JUMP:
            next_target = {page_latch_i[6:3], d.lit11};
         OP_BREL:
            next_target = PC_W'(pc_i + PC_W'(1) + {{(PC_W-9){d.lit9[8]}}, d.lit9});
         default:
            next_target = PC_W'(pc_i + PC_W'(1));
      endcase
   end

   always_comb begin
      next_state = state;
      if (q == Q_LAST) begin
         case (state)
            S_EXEC:  next_state = ind_pend ? S_IND :
                                  (fields_o.two_cycle || skip_hit) ? S_NOP : S_FETCH;
            S_IND:   next_state = (fields_o.two_cycle || skip_hit) ? S_NOP : S_FETCH;
            S_NOP:   next_state = S_FETCH;
            default: next_state = S_FETCH;
         endcase
      end else if (take) begin
         next_state = S_EXEC;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Quarter counter: four clocks per instruction cycle
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) q <= 2'h0;
      else           q <= q + 2'h1;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) state <= S_FETCH;
      else           state <= next_state;
   end

   // Ready only at the first quarter of an idle cycle
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) instr_ready_o <= 1'b0;
      else           instr_ready_o <= (next_state == S_FETCH) && (q == Q_LAST);
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fields_o    <= '0;
         target_pc_o <= '0;
         ind_pend    <= 1'b0;
      end else if (take) begin
         fields_o    <= d;
         target_pc_o <= next_target;
         ind_pend    <= ind_now;
      end
   end

   // Read strobe and stack push as one-clock pulses
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         file_read_o <= 1'b0;
         push_o      <= 1'b0;
      end else begin
         file_read_o <= take && d.names_file;
         push_o      <= take && (d.op inside {OP_CALL, OP_CALLW});
      end
   end

   // Cost grows when the skip test proves true
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cost_o   <= 2'h0;
         skip_hit <= 1'b0;
      end else if (take) begin
         cost_o   <= 2'h1 + 2'(d.two_cycle) + 2'(ind_now);
         skip_hit <= 1'b0;
      end else if (state == S_EXEC && q == 2'h2 && skip_now) begin
         cost_o   <= cost_o + 2'h1;
         skip_hit <= 1'b1;
      end
   end

   // Flag write window is the last quarter of execution
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) flags_we_o <= 1'b0;
      else           flags_we_o <= (state == S_EXEC) && (q == 2'h2) &&
                                   (fields_o.flags != '0);
   end

   assign exec_o      = state[1];
   assign ind_cycle_o = state[2];
   assign nop_cycle_o = state[3];

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   property p_quarter;
      q == Q_LAST |=> q == 2'h0 ##3 q == Q_LAST;
   endproperty
   a_quarter: assert property (p_quarter) else $error("cycle not four clocks");

   property p_take;
      take |=> exec_o && fields_o.op == $past(d.op);
   endproperty
   a_take: assert property (p_take) else $error("word not taken");

   property p_single;
      take && !d.two_cycle && !d.skip_kind && !ind_now |-> ##4 instr_ready_o;
   endproperty
   a_single: assert property (p_single) else $error("single cycle overran");

   property p_two;
      take && d.two_cycle && !ind_now |-> ##4 nop_cycle_o [*4] ##1 instr_ready_o;
   endproperty
   a_two: assert property (p_two) else $error("branch not two cycles");

   property p_ind;
      take && ind_now |-> ##4 ind_cycle_o && cost_o >= 2'h2;
   endproperty
   a_ind: assert property (p_ind) else $error("indirect cycle missing");

   property p_read;
      take && d.names_file |=> file_read_o ##1 !file_read_o;
   endproperty
   a_read: assert property (p_read) else $error("no file read");

   property p_fields;
      file_read_o |-> fields_o.dest_file == $past(instr_i[7]) &&
                      fields_o.file_addr == $past(instr_i[6:0]) &&
                      fields_o.bit_num == $past(instr_i[9:7]);
   endproperty
   a_fields: assert property (p_fields) else $error("field split wrong");

   property p_skip;
      exec_o && q == 2'h2 && fields_o.op == OP_DECSZ && file_data_i == 8'h01 &&
      !ind_pend |-> ##2 nop_cycle_o;
   endproperty
   a_skip: assert property (p_skip) else $error("zero skip lost");

   property p_call;
      push_o && fields_o.op == OP_CALL |-> target_pc_o[10:0] == fields_o.lit11 &&
                 target_pc_o[14:11] == $past(page_latch_i[6:3]);
   endproperty
   a_call: assert property (p_call) else $error("call target wrong");

   property p_noflag;
      exec_o && fields_o.flags == '0 |=> !flags_we_o;
   endproperty
   a_noflag: assert property (p_noflag) else $error("stray flag write");

   c_single: cover property (take ##4 take);
   c_skip:   cover property (exec_o && skip_hit ##1 nop_cycle_o);
   c_ind:    cover property (ind_cycle_o ##4 nop_cycle_o);
endmodule // instr_decoder

// *** logic/instr_decode_pkg.sv ***
// Constants, opcode tags and carriers for the 14-bit instruction decoder.
// Assumes one clock; an instruction cycle is four of its edges.
package instr_decode_pkg;
   localparam int          INSTR_W   = 14;
   localparam int          PC_W      = 15;
   localparam int          Q_PER_CYC = 4;
   localparam logic [1:0]  Q_LAST    = 2'(Q_PER_CYC - 1);
   localparam logic [6:0]  ADDR_IND0 = 7'h00;
   localparam logic [6:0]  ADDR_IND1 = 7'h01;
   // Prefix codes, left-aligned in the word except PFX_BANK (bits 7:5) and PFX_INCD (bits 6:4)
   localparam logic [1:0]  PFX_BIT   = 2'h1;
   localparam logic [2:0]  PFX_CALL  = 3'h4;
   localparam logic [2:0]  PFX_JUMP  = 3'h5;
   localparam logic [4:0]  PFX_REL   = 5'h19;
   localparam logic [6:0]  PFX_PAGE  = 7'h63;
   localparam logic [6:0]  PFX_PADD  = 7'h62;
   localparam logic [6:0]  PFX_IDXR  = 7'h7e;
   localparam logic [6:0]  PFX_IDXW  = 7'h7f;
   localparam logic [2:0]  PFX_BANK  = 3'h1;
   localparam logic [2:0]  PFX_INCD  = 3'h1;
   localparam logic [13:0] W_RETURN  = 14'h0008;
   localparam logic [13:0] W_RETFIE  = 14'h0009;
   localparam logic [13:0] W_CALLW   = 14'h000a;
   localparam logic [13:0] W_BRW     = 14'h000b;

   typedef enum logic [5:0] {
      OP_OTHER, OP_NOP, OP_ADD, OP_ADDC, OP_AND, OP_OR, OP_XOR, OP_SUB, OP_SUBB,
      OP_ASR, OP_LSL, OP_LSR, OP_RLC, OP_RRC, OP_CLR_FILE, OP_CLR_WORK, OP_MOV_TO_FILE,
      OP_COMPL, OP_DEC, OP_INC, OP_MOV_FILE, OP_SWAP, OP_DECSZ, OP_INCSZ,
      OP_BCLR, OP_BSET, OP_TSC, OP_TSS, OP_ADDL, OP_ANDL, OP_ORL, OP_MOVL,
      OP_SUBL, OP_RETL, OP_BANK, OP_PAGE, OP_CALL, OP_JUMP, OP_BREL, OP_BRW,
      OP_CALLW, OP_RET, OP_RETFIE, OP_PADD, OP_IDXR, OP_IDXW, OP_INCDR, OP_INCDW
   } op_t;

   typedef enum logic [3:0] {
      S_FETCH = 4'h1,
      S_EXEC  = 4'h2,
      S_IND   = 4'h4,
      S_NOP   = 4'h8
   } state_t;

   typedef struct packed {
      logic wr_c;
      logic wr_digit;
      logic wr_z;
   } flags_t;

   typedef struct packed {
      op_t         op;
      logic        dest_file;
      logic [6:0]  file_addr;
      logic [2:0]  bit_num;
      logic [7:0]  lit8;
      logic [10:0] lit11;
      logic [6:0]  lit7;
      logic [4:0]  lit5;
      logic [8:0]  lit9;
      logic        ptr_sel;
      logic [5:0]  offset6;
      logic [1:0]  mode;
      flags_t      flags;
      logic        names_file;
      logic        two_cycle;
      logic        skip_kind;
   } fields_t;
endpackage

// *** sim/prog_mem_model.sv ***
// Program memory model that offers one word per instruction.
// Assumes the bench loads words by index; the low six address bits select.
`timescale 1ns/1ps

module prog_mem_model (
   input  wire logic        clk_i,
   input  wire logic [14:0] addr_i,
   input  wire logic        valid_i,
   output logic      [13:0] word_o
);
   logic [13:0] mem [64];
   logic [13:0] last;

   // Idle bus shows the inverse of the last word, so stale data never matches
   assign word_o = valid_i ? mem[addr_i[5:0]] : ~last;

   always_ff @(posedge clk_i) begin
      if (valid_i) begin
         last <= mem[addr_i[5:0]];
      end
   end
endmodule // prog_mem_model

// *** sim/fourteen_bit_instr_decode_bench.sv ***
// Self-checking bench for the instruction decoder and cycle sequencer.
// Assumes one instruction offered at a time, valid dropped after each take.
`timescale 1ns/1ps

module fourteen_bit_instr_decode_bench;
   import instr_decode_pkg::*;
   logic        clk_i, arst_n_i, instr_valid_i;
   logic [13:0] instr_i;
   logic [14:0] pc_i, target_pc_o;
   logic [6:0]  page_latch_i;
   logic [1:0]  ptr_msb_i, cost_o;
   logic [7:0]  file_data_i;
   logic        instr_ready_o, file_read_o, flags_we_o, push_o;
   logic        exec_o, ind_cycle_o, nop_cycle_o;
   fields_t     fields_o;
   int          n_fail = 0;
   int          tests_run = 0;
   int          cycles = 0;

   prog_mem_model i_prog_mem_model (.clk_i(clk_i), .addr_i(pc_i), .valid_i(instr_valid_i),
      .word_o(instr_i));

   instr_decoder i_instr_decoder (.clk_i(clk_i), .arst_n_i(arst_n_i), .instr_i(instr_i),
      .instr_valid_i(instr_valid_i), .pc_i(pc_i), .page_latch_i(page_latch_i),
      .ptr_msb_i(ptr_msb_i), .file_data_i(file_data_i), .instr_ready_o(instr_ready_o),
      .fields_o(fields_o), .file_read_o(file_read_o), .flags_we_o(flags_we_o),
      .push_o(push_o), .target_pc_o(target_pc_o), .cost_o(cost_o), .exec_o(exec_o),
      .ind_cycle_o(ind_cycle_o), .nop_cycle_o(nop_cycle_o));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %0h want %0h", $time, seen, exp);
      end
   endtask

   // Offers one word, then judges decode, pulses and cycle count
   task automatic run(input logic [13:0] w, input logic [14:0] pc, input logic [1:0] ptr,
      input logic [7:0] fd, input op_t op, input int cost, input logic fr, input logic fw,
      input logic ind);
      int n;
      int nf;
      int ni;
      int nn;
      logic [14:0] tgt;
      tgt = pc + 15'h1;
      if (op == OP_CALL || op == OP_JUMP) tgt = {page_latch_i[6:3], w[10:0]};
      if (op == OP_BREL) tgt = pc + 15'h1 + {{6{w[8]}}, w[8:0]};
      i_prog_mem_model.mem[pc[5:0]] = w;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_i);
         instr_valid_i <= 1'b1;
         pc_i <= pc;
         ptr_msb_i <= ptr;
         file_data_i <= fd;
         #1;
         if (instr_ready_o === 1'b1) break;
      end
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1;
      check(exec_o, 1'b1);
      check(fields_o.op, op);
      check(push_o, op == OP_CALL || op == OP_CALLW);
      check(file_read_o, fr);
      check(target_pc_o, tgt);
      nf = (flags_we_o === 1'b1);
      ni = 0;
      nn = 0;
      for (n = 1; n < 20; n++) begin
         @(posedge clk_i);
         #1;
         nf += (flags_we_o === 1'b1);
         ni += (ind_cycle_o === 1'b1);
         nn += (nop_cycle_o === 1'b1);
         if (instr_ready_o === 1'b1) break;
      end
      check(cost_o, cost);
      check(n + 1, 4 * cost);
      check(ni, ind ? 4 : 0);
      check(nn, (cost - ind > 1) ? 4 : 0);
      check(nf, fw);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_byte;
      logic [5:0] code [19] = '{6'h07, 6'h3d, 6'h05, 6'h04, 6'h06, 6'h02, 6'h3b, 6'h37,
         6'h35, 6'h36, 6'h0d, 6'h0c, 6'h09, 6'h03, 6'h0a, 6'h08, 6'h0e, 6'h00, 6'h01};
      op_t ops [19] = '{OP_ADD, OP_ADDC, OP_AND, OP_OR, OP_XOR, OP_SUB, OP_SUBB, OP_ASR,
         OP_LSL, OP_LSR, OP_RLC, OP_RRC, OP_COMPL, OP_DEC, OP_INC, OP_MOV_FILE, OP_SWAP,
         OP_MOV_TO_FILE, OP_CLR_FILE};
      logic d;
      for (int i = 0; i < 19; i++) begin
         d = (i < 17) ? i[0] : 1'b1;
         run({code[i], d, 7'h7f}, 15'(i + 8), 2'b11, 8'h5a, ops[i], 1, 1'b1, i < 16 || i > 17,
            1'b0);
         check(fields_o.dest_file, d);
         check(fields_o.file_addr, 7'h7f);
      end
      run(14'h0103, 15'h0030, 2'b00, 8'h00, OP_CLR_WORK, 1, 1'b0, 1'b1, 1'b0);
      $display("byte operations done");
   endtask

   task automatic t_skip;
      run({6'h0b, 1'b1, 7'h20}, 15'h0010, 2'b00, 8'h01, OP_DECSZ, 2, 1'b1, 1'b0, 1'b0);
      run({6'h0b, 1'b0, 7'h20}, 15'h0011, 2'b00, 8'h02, OP_DECSZ, 1, 1'b1, 1'b0, 1'b0);
      run({6'h0f, 1'b1, 7'h21}, 15'h0012, 2'b00, 8'hff, OP_INCSZ, 2, 1'b1, 1'b0, 1'b0);
      run({6'h0f, 1'b1, 7'h21}, 15'h0013, 2'b00, 8'h00, OP_INCSZ, 1, 1'b1, 1'b0, 1'b0);
      run({4'h6, 3'd7, 7'h22}, 15'h0014, 2'b00, 8'h7f, OP_TSC, 2, 1'b1, 1'b0, 1'b0);
      run({4'h6, 3'd7, 7'h22}, 15'h0015, 2'b00, 8'h80, OP_TSC, 1, 1'b1, 1'b0, 1'b0);
      run({4'h7, 3'd0, 7'h23}, 15'h0016, 2'b00, 8'h01, OP_TSS, 2, 1'b1, 1'b0, 1'b0);
      run({4'h7, 3'd0, 7'h23}, 15'h0017, 2'b00, 8'hfe, OP_TSS, 1, 1'b1, 1'b0, 1'b0);
      run({4'h4, 3'd7, 7'h24}, 15'h0018, 2'b00, 8'hff, OP_BCLR, 1, 1'b1, 1'b0, 1'b0);
      check(fields_o.bit_num, 3'd7);
      run({4'h5, 3'd2, 7'h24}, 15'h0019, 2'b00, 8'h00, OP_BSET, 1, 1'b1, 1'b0, 1'b0);
      check(fields_o.bit_num, 3'd2);
      $display("skip and bit operations done");
   endtask

   task automatic t_lit;
      logic [5:0] code [5] = '{6'h3e, 6'h39, 6'h38, 6'h30, 6'h3c};
      op_t ops [5] = '{OP_ADDL, OP_ANDL, OP_ORL, OP_MOVL, OP_SUBL};
      for (int i = 0; i < 5; i++) begin
         run({code[i], 8'(8'ha5 + i)}, 15'(i + 32), 2'b00, 8'h00, ops[i], 1, 1'b0, i != 3,
            1'b0);
         check(fields_o.lit8, 8'(8'ha5 + i));
      end
      run(14'h003f, 15'h0040, 2'b00, 8'h00, OP_BANK, 1, 1'b0, 1'b0, 1'b0);
      check(fields_o.lit5, 5'h1f);
      run(14'h31ff, 15'h0041, 2'b00, 8'h00, OP_PAGE, 1, 1'b0, 1'b0, 1'b0);
      check(fields_o.lit7, 7'h7f);
      $display("literal operations done");
   endtask

   task automatic t_branch;
      run(14'h27ff, 15'h0123, 2'b00, 8'h00, OP_CALL, 2, 1'b0, 1'b0, 1'b0);
      check(fields_o.lit11, 11'h7ff);
      run(14'h2801, 15'h0124, 2'b00, 8'h00, OP_JUMP, 2, 1'b0, 1'b0, 1'b0);
      run(14'h3300, 15'h0200, 2'b00, 8'h00, OP_BREL, 2, 1'b0, 1'b0, 1'b0);
      check(fields_o.lit9, 9'h100);
      run(14'h32ff, 15'h7ff0, 2'b00, 8'h00, OP_BREL, 2, 1'b0, 1'b0, 1'b0);
      $display("branch operations done");
   endtask

   task automatic t_ind;
      run({6'h07, 1'b1, 7'h00}, 15'h0050, 2'b01, 8'h00, OP_ADD, 2, 1'b1, 1'b1, 1'b1);
      run({6'h07, 1'b1, 7'h01}, 15'h0051, 2'b01, 8'h00, OP_ADD, 1, 1'b1, 1'b1, 1'b0);
      run({6'h07, 1'b0, 7'h01}, 15'h0052, 2'b10, 8'h00, OP_ADD, 2, 1'b1, 1'b1, 1'b1);
      run({6'h0b, 1'b1, 7'h00}, 15'h0053, 2'b01, 8'h01, OP_DECSZ, 3, 1'b1, 1'b0, 1'b1);
      $display("indirect access done");
   endtask

   // Pointer forms, returns, register calls and one unlisted encoding
   task automatic t_ptr;
      run(14'h316a, 15'h0060, 2'b11, 8'h00, OP_PADD, 1, 1'b0, 1'b0, 1'b0);
      check(fields_o.ptr_sel, 1'b1);
      check(fields_o.offset6, 6'h2a);
      run(14'h3f05, 15'h0061, 2'b01, 8'h00, OP_IDXR, 2, 1'b0, 1'b1, 1'b1);
      check(fields_o.ptr_sel, 1'b0);
      run(14'h3fff, 15'h0062, 2'b01, 8'h00, OP_IDXW, 1, 1'b0, 1'b0, 1'b0);
      check(fields_o.offset6, 6'h3f);
      run(14'h0016, 15'h0063, 2'b10, 8'h00, OP_INCDR, 2, 1'b0, 1'b1, 1'b1);
      check(fields_o.mode, 2'h2);
      check(fields_o.ptr_sel, 1'b1);
      run(14'h001b, 15'h0064, 2'b10, 8'h00, OP_INCDW, 1, 1'b0, 1'b0, 1'b0);
      check(fields_o.mode, 2'h3);
      run(14'h0008, 15'h0065, 2'b00, 8'h00, OP_RET, 2, 1'b0, 1'b0, 1'b0);
      run(14'h0009, 15'h0066, 2'b00, 8'h00, OP_RETFIE, 2, 1'b0, 1'b0, 1'b0);
      run(14'h000a, 15'h0067, 2'b00, 8'h00, OP_CALLW, 2, 1'b0, 1'b0, 1'b0);
      run(14'h000b, 15'h0068, 2'b00, 8'h00, OP_BRW, 2, 1'b0, 1'b0, 1'b0);
      run(14'h3412, 15'h0069, 2'b00, 8'h00, OP_RETL, 2, 1'b0, 1'b0, 1'b0);
      check(fields_o.lit8, 8'h12);
      run(14'h0000, 15'h006a, 2'b00, 8'h00, OP_NOP, 1, 1'b0, 1'b0, 1'b0);
      run(14'h0064, 15'h006b, 2'b00, 8'h00, OP_OTHER, 1, 1'b0, 1'b0, 1'b0);
      $display("pointer and control operations done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Ceiling is several times the expected run, about 550 clocks
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_fail++;
         summarize();
      end
   end

   initial begin
      arst_n_i = 1'b0;
      instr_valid_i = 1'b0;
      pc_i = 15'h0000;
      page_latch_i = 7'h5a;
      ptr_msb_i = 2'b00;
      file_data_i = 8'h00;
      repeat (20) @(posedge clk_i);
      arst_n_i <= 1'b1;
      t_byte();
      t_skip();
      t_lit();
      t_branch();
      t_ind();
      t_ptr();
      summarize();
   end
endmodule // fourteen_bit_instr_decode_bench
